/* File: psm_consts.svh */
`ifndef PSM_CONSTS_SVH
`define PSM_CONSTS_SVH

// ==========================================================
// Register offsets
`define PSM_POWER_CONTROL_ADDR   8'h87
`define PSM_STAT_ADDR   8'h8e
`define PSM_WDC_ADDR    8'h8f

// ==========================================================
// Power control fields
`define PSM_B_IDLE      0
`define PSM_B_ARM       1
`define PSM_B_SLOW      4
`define PSM_B_IDLE_START_BIT      5
`define PSM_B_PDS       6

// ==========================================================
// Watchdog control fields
`define PSM_B_WSTART    0
`define PSM_B_WDCLR     2
`define PSM_B_OWCLR     3

// ==========================================================
// Reset values and timing counts
`define PSM_RDATA_RST   8'h00
`define PSM_MC_CLKS     12
`define PSM_HRST_MCS    2
`define PSM_SLOW_LAST   3'h7

`endif

/* File: psm_pkg.sv */
package psm_pkg;

    // ======================================================
    // Operating modes
    typedef enum logic [2:0] {
        MD_RUN,
        MD_IDLE,
        MD_SWPD,
        MD_HRST,
        MD_HOFF,
        MD_HWAKE,
        MD_OWAIT
    } psm_mode_t;

    // ======================================================
    // Whole block state
    typedef struct packed {
        psm_mode_t  mode;
        logic [1:0] pse_s;
        logic [1:0] hsl_s;
        logic [1:0] osc_s;
        logic [3:0] mc;
        logic [2:0] div;
        logic [1:0] hcnt;
        logic       slow_req;
        logic       slow_on;
        logic       idle_arm;
        logic       pd_arm;
        logic       auto_wd;
        logic       wd_run;
        logic       wd_load;
        logic       wd_flag;
        logic       owd_flag;
        logic       cpu_en;
        logic       per_en;
        logic       wd_en;
        logic       osc_en;
        logic       float_p;
        logic       hold;
        logic       int_rst;
        logic       rc_sel;
        logic       idle_o;
        logic       swpd_o;
        logic [7:0] rdata;
    } psm_state_t;

endpackage : psm_pkg

/* File: psm_ctrl.sv */
// How it works
// - Power-save pin high makes every software mode entry sequence ignored.
// - Power-save pin high at reset starts the watchdog as reset ends.
// - Power-save pin low lets software enter modes and start the watchdog.
// - Pin changes while running only gate software modes, not the watchdog.
// - Power-save pin never affects hardware power-down.
// - Software modes are chosen through the power control register at 87h.
// - Slow mode divides all derived clock enables by eight.
// - Slow bit set enters slow mode within two machine cycles; clear leaves.
// - Idle stops the processor clock, peripherals except watchdog keep running.
// - Any enabled interrupt ends idle and the processor resumes.
// - Reset ends idle; two machine cycles of reset suffice.
// - In idle ports hold, alternate outputs run, strobes stay high.
// - Power-down arm write, then start write; both bits clear themselves.
// - Start write is the last one executed; only reset leaves power-down.
// - Hard sleep pin sampled each machine cycle; low enters hardware power-down from run or idle, not from software power-down.
// - Hardware power-down first runs internal reset, stopping watchdog, clearing flag.
// - Then oscillators stop and pins float while the pin stays low.
// - On release pins leave float first, then oscillators restart.
// - Oscillator watchdog holds reset on RC clock until main oscillator runs.
// - Automatic watchdog start also applies when leaving hardware power-down.
// - Reset overrides hardware power-down; system keeps reset low meanwhile.
// - Power-save pin sampled only in reset for automatic watchdog start.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "psm_consts.svh"

module psm_ctrl
    import psm_pkg::*;
#(
    parameter int unsigned MC_CLKS  = `PSM_MC_CLKS,
    parameter int unsigned HRST_MCS = `PSM_HRST_MCS
) (
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic       CE,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output var  logic [7:0] RDATA,
    input  wire logic       POWER_SAVE_ENABLE_PIN,
    input  wire logic       HARD_SLEEP_PIN_N,
    input  wire logic       MAIN_OSC_RUNNING,
    input  wire logic       IRQ_PENDING,
    input  wire logic       WDOG_TIMEOUT,
    output var  logic       CPU_CLK_EN,
    output var  logic       PERIPH_CLK_EN,
    output var  logic       WDOG_CLK_EN,
    output var  logic       SLOW_ACTIVE,
    output var  logic       OSC_EN,
    output var  logic       RC_CLK_SEL,
    output var  logic       INT_RESET,
    output var  logic       PINS_FLOAT,
    output var  logic       PORT_HOLD,
    output var  logic       STROBE_HOLD_HIGH,
    output var  logic       WDOG_RUN,
    output var  logic       WDOG_LOAD,
    output var  logic       WDOG_RESET_FLAG,
    output var  logic       OWD_FLAG,
    output var  logic       IDLE_ACTIVE,
    output var  logic       SWPD_ACTIVE
);

    // ======================================================
    // Parameter checks
    if (MC_CLKS < 2 || MC_CLKS > 16) begin : g_bad_mc
        $error("MC_CLKS must lie in 2..16");
    end
    if (HRST_MCS < 1 || HRST_MCS > 4) begin : g_bad_hrst
        $error("HRST_MCS must lie in 1..4");
    end

    localparam logic [3:0] MC_LAST   = 4'(MC_CLKS - 1);
    localparam logic [1:0] HRST_LAST = 2'(HRST_MCS - 1);

    // ======================================================
    // State
    psm_state_t s;
    psm_state_t n;

    logic mc_end;
    logic sw_ok;
    logic hw_busy;
    logic wr_ok;
    logic wr_power_control;
    logic wr_wdc;
    logic tick;

    always_comb begin
        n       = s;
        mc_end  = (s.mc == MC_LAST);
        sw_ok   = !s.pse_s[1];
        hw_busy = (s.mode == MD_HRST) || (s.mode == MD_HOFF)
               || (s.mode == MD_HWAKE) || (s.mode == MD_OWAIT);
        wr_ok   = WR && !hw_busy;
        wr_power_control = wr_ok && (ADDR == `PSM_POWER_CONTROL_ADDR);
        wr_wdc  = wr_ok && (ADDR == `PSM_WDC_ADDR);
        tick    = 1'b1;

        if (CE) begin
            // ==============================================
            // Pin synchronisers and cycle counters
            n.pse_s   = {s.pse_s[0], POWER_SAVE_ENABLE_PIN};
            n.hsl_s   = {s.hsl_s[0], HARD_SLEEP_PIN_N};
            n.osc_s   = {s.osc_s[0], MAIN_OSC_RUNNING};
            n.mc      = mc_end ? 4'h0 : s.mc + 4'h1;
            n.div     = s.div + 3'h1;
            n.wd_load = 1'b0;

            // ==============================================
            // Register reads
            n.rdata = `PSM_RDATA_RST;
            if (RD) begin
                case (ADDR)
                    `PSM_POWER_CONTROL_ADDR:
                        n.rdata = {3'h0, s.slow_req, 4'h0};
                    `PSM_STAT_ADDR:
                        n.rdata = {s.owd_flag, s.wd_flag, s.wd_run,
                                   s.auto_wd, s.pse_s[1], s.slow_on,
                                   s.mode == MD_IDLE, s.float_p};
                    `PSM_WDC_ADDR:
                        n.rdata = {4'h0, s.owd_flag, s.wd_flag,
                                   1'b0, s.wd_run};
                    default:
                        n.rdata = `PSM_RDATA_RST;
                endcase
            end

            // ==============================================
            // Power control writes and guarded sequences
            if (wr_ok) begin
                n.idle_arm = 1'b0;
                n.pd_arm   = 1'b0;
            end
            if (wr_power_control) begin
                if (!WDATA[`PSM_B_SLOW]) begin
                    n.slow_req = 1'b0;
                end else if (sw_ok) begin
                    n.slow_req = 1'b1;
                end
                if (sw_ok && WDATA[`PSM_B_IDLE]
                    && !WDATA[`PSM_B_IDLE_START_BIT]) begin
                    n.idle_arm = 1'b1;
                end
                if (sw_ok && WDATA[`PSM_B_ARM]
                    && !WDATA[`PSM_B_PDS]) begin
                    n.pd_arm = 1'b1;
                end
                if (sw_ok && s.mode == MD_RUN) begin
                    if (WDATA[`PSM_B_PDS] && s.pd_arm) begin
                        n.mode = MD_SWPD;
                    end else if (WDATA[`PSM_B_IDLE_START_BIT]
                                 && s.idle_arm) begin
                        n.mode = MD_IDLE;
                    end
                end
            end

            // ==============================================
            // Slow mode entry at a machine cycle boundary
            if (!s.slow_req) begin
                n.slow_on = 1'b0;
            end else if (mc_end) begin
                n.slow_on = 1'b1;
            end

            // ==============================================
            // Watchdog control
            if (wr_wdc) begin
                if (WDATA[`PSM_B_WSTART] && !s.wd_run) begin
                    n.wd_run  = 1'b1;
                    n.wd_load = 1'b1;
                end
                if (WDATA[`PSM_B_WDCLR]) begin
                    n.wd_flag = 1'b0;
                end
                if (WDATA[`PSM_B_OWCLR]) begin
                    n.owd_flag = 1'b0;
                end
            end
            if (WDOG_TIMEOUT && s.wd_run) begin
                n.wd_flag = 1'b1;
            end

            // ==============================================
            // Mode sequencing
            case (s.mode)
                MD_RUN: begin
                end
                MD_IDLE: begin
                    if (IRQ_PENDING) begin
                        n.mode = MD_RUN;
                    end
                end
                MD_SWPD: begin
                    n.mode = MD_SWPD;
                end
                MD_HRST: begin
                    if (mc_end) begin
                        if (s.hcnt == HRST_LAST) begin
                            n.mode = MD_HOFF;
                            n.hcnt = 2'h0;
                        end else begin
                            n.hcnt = s.hcnt + 2'h1;
                        end
                    end
                end
                MD_HOFF: begin
                    if (mc_end && s.hsl_s[1]) begin
                        n.mode = MD_HWAKE;
                    end
                end
                MD_HWAKE: begin
                    n.mode = MD_OWAIT;
                end
                MD_OWAIT: begin
                    if (s.osc_s[1]) begin
                        n.mode     = MD_RUN;
                        n.owd_flag = 1'b1;
                        if (s.auto_wd) begin
                            n.wd_run  = 1'b1;
                            n.wd_load = 1'b1;
                        end
                    end
                end
                default: begin
                    n.mode = MD_RUN;
                end
            endcase

            // Hard sleep detect, independent of power-save pin
            if (mc_end && !s.hsl_s[1]
                && (s.mode == MD_RUN || s.mode == MD_IDLE)) begin
                n.mode     = MD_HRST;
                n.hcnt     = 2'h0;
                n.wd_run   = 1'b0;
                n.wd_flag  = 1'b0;
                n.wd_load  = 1'b0;
                n.slow_req = 1'b0;
                n.slow_on  = 1'b0;
                n.idle_arm = 1'b0;
                n.pd_arm   = 1'b0;
            end

            // ==============================================
            // Clock enables and pin controls
            tick = !n.slow_on || (n.div == `PSM_SLOW_LAST);
            n.cpu_en  = tick && (n.mode == MD_RUN);
            n.per_en  = tick && (n.mode == MD_RUN
                                 || n.mode == MD_IDLE);
            n.wd_en   = tick && n.wd_run
                        && (n.mode == MD_RUN);
            n.hold    = (n.mode == MD_IDLE);
            n.float_p = (n.mode == MD_HOFF);
            n.osc_en  = (n.mode != MD_HOFF)
                        && (n.mode != MD_HWAKE)
                        && (n.mode != MD_SWPD);
            n.int_rst = (n.mode == MD_HRST)
                        || (n.mode == MD_HWAKE)
                        || (n.mode == MD_OWAIT);
            n.rc_sel  = (n.mode == MD_OWAIT);
            n.idle_o  = (n.mode == MD_IDLE);
            n.swpd_o  = (n.mode == MD_SWPD);
        end

        // ==================================================
        // Reset, overriding every mode
        if (RST) begin
            n          = '0;
            n.mode     = MD_RUN;
            n.pse_s    = {s.pse_s[0], POWER_SAVE_ENABLE_PIN};
            n.hsl_s    = {s.hsl_s[0], HARD_SLEEP_PIN_N};
            n.osc_s    = {s.osc_s[0], MAIN_OSC_RUNNING};
            n.auto_wd  = s.pse_s[1];
            n.wd_run   = s.pse_s[1];
            n.osc_en   = 1'b1;
            n.rdata    = `PSM_RDATA_RST;
        end
    end

    always_ff @(posedge CLK) begin
        s <= n;
    end

    // ======================================================
    // Outputs
    assign RDATA            = s.rdata;
    assign CPU_CLK_EN       = s.cpu_en;
    assign PERIPH_CLK_EN    = s.per_en;
    assign WDOG_CLK_EN      = s.wd_en;
    assign SLOW_ACTIVE      = s.slow_on;
    assign OSC_EN           = s.osc_en;
    assign RC_CLK_SEL       = s.rc_sel;
    assign INT_RESET        = s.int_rst;
    assign PINS_FLOAT       = s.float_p;
    assign PORT_HOLD        = s.hold;
    assign STROBE_HOLD_HIGH = s.hold;
    assign WDOG_RUN         = s.wd_run;
    assign WDOG_LOAD        = s.wd_load;
    assign WDOG_RESET_FLAG  = s.wd_flag;
    assign OWD_FLAG         = s.owd_flag;
    assign IDLE_ACTIVE      = s.idle_o;
    assign SWPD_ACTIVE      = s.swpd_o;

endmodule : psm_ctrl
`default_nettype wire

/* File: psm_ctrl_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module psm_ctrl_sva
    import psm_pkg::*;
#(
    parameter int unsigned MC_CLKS = 12
) (
    input wire logic       CLK,
    input wire logic       RST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       POWER_SAVE_ENABLE_PIN,
    input wire logic       IRQ_PENDING,
    input wire logic       CPU_CLK_EN,
    input wire logic       SLOW_ACTIVE,
    input wire logic       OSC_EN,
    input wire logic       RC_CLK_SEL,
    input wire logic       INT_RESET,
    input wire logic       PINS_FLOAT,
    input wire logic       PORT_HOLD,
    input wire logic       STROBE_HOLD_HIGH,
    input wire logic       WDOG_RUN,
    input wire logic       WDOG_RESET_FLAG,
    input wire logic       OWD_FLAG,
    input wire logic       IDLE_ACTIVE,
    input wire logic       SWPD_ACTIVE
);
    localparam int SLOW_MAX = MC_CLKS + 1;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    // ====================================
    // Software modes
    sequence s_slow_set;
        WR && ADDR == 8'h87 && WDATA[4] && !POWER_SAVE_ENABLE_PIN
            && !INT_RESET && !PINS_FLOAT;
    endsequence
    property p_block;
        $rose(IDLE_ACTIVE) || $rose(SLOW_ACTIVE)
            |-> !$past(POWER_SAVE_ENABLE_PIN, 3);
    endproperty
    a_block: assert property (p_block) else $error("mode entered while blocked");
    property p_slow_in;
        s_slow_set |-> ##[1:SLOW_MAX] SLOW_ACTIVE;
    endproperty
    a_slow_in: assert property (p_slow_in) else $error("slow entry late");
    property p_slow_div;
        SLOW_ACTIVE && CPU_CLK_EN |=> (!CPU_CLK_EN || !SLOW_ACTIVE) [*7];
    endproperty
    a_slow_div: assert property (p_slow_div) else $error("slow not by 8");
    property p_idle_gate;
        IDLE_ACTIVE |-> !CPU_CLK_EN && PORT_HOLD && STROBE_HOLD_HIGH;
    endproperty
    a_idle_gate: assert property (p_idle_gate) else $error("idle gating");
    property p_idle_irq;
        IDLE_ACTIVE && IRQ_PENDING |=> !IDLE_ACTIVE;
    endproperty
    a_idle_irq: assert property (p_idle_irq) else $error("idle kept");
    property p_swpd;
        SWPD_ACTIVE |=> SWPD_ACTIVE && !OSC_EN && !CPU_CLK_EN;
    endproperty
    a_swpd: assert property (p_swpd) else $error("power-down left");
    // ====================================
    // Hardware power-down and restart
    property p_float;
        PINS_FLOAT |-> !OSC_EN;
    endproperty
    a_float: assert property (p_float) else $error("osc on in float");
    property p_hpd_in;
        $rose(PINS_FLOAT) |-> $past(INT_RESET) && !WDOG_RUN
            && !WDOG_RESET_FLAG;
    endproperty
    a_hpd_in: assert property (p_hpd_in) else $error("no reset first");
    property p_wake;
        $fell(PINS_FLOAT) |-> INT_RESET && !OSC_EN;
    endproperty
    a_wake: assert property (p_wake) else $error("wake order");
    property p_owd;
        $fell(RC_CLK_SEL) |-> OWD_FLAG && !INT_RESET;
    endproperty
    a_owd: assert property (p_owd) else $error("restart flag");
    property p_auto;
        $fell(RST) |-> WDOG_RUN == $past(POWER_SAVE_ENABLE_PIN, 3);
    endproperty
    a_auto: assert property (p_auto) else $error("auto start");
endmodule : psm_ctrl_sva
bind psm_ctrl psm_ctrl_sva #(.MC_CLKS(MC_CLKS)) u_psm_ctrl_sva (.*);
`default_nettype wire

/* File: psm_board.sv */
`timescale 1ns/1ps
`default_nettype none
module psm_board #(
    parameter int unsigned OSC_START = 5
) (
    input  wire logic clk,
    input  wire logic osc_en,
    input  wire logic sleep_req,
    input  wire logic pse_low,
    output var  logic hard_sleep_n,
    output var  logic main_osc_run,
    output var  logic pse_pin
);
    int unsigned cnt;
    // ====================================
    // Oscillator start-up delay
    always_ff @(posedge clk) begin
        if (!osc_en) begin
            cnt <= 0;
        end else if (cnt < OSC_START) begin
            cnt <= cnt + 1;
        end
    end
    assign main_osc_run = osc_en && cnt == OSC_START;
    assign hard_sleep_n = !sleep_req;
    assign pse_pin      = !pse_low;
endmodule : psm_board
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int unsigned MC = 2;
    logic       CLK = 0, RST = 1, WR = 0, RD = 0, irq = 0, wto = 0;
    logic       sleep_req = 0, pse_low = 0, pse, hsl_n, orun;
    logic [7:0] ADDR = 8'h00, WDATA = 8'h00, rdata;
    logic       cpu, per, wdc, slow, osc, rc, irst, flt, hold, strb;
    logic       wrun, wload, wflag, oflag, idle, swpd;
    int         num_errors = 0, tests_run = 0, i, n;
    always #10 CLK = ~CLK;
    psm_ctrl #(.MC_CLKS(MC), .HRST_MCS(1)) u_psm_ctrl (
        .CLK(CLK), .RST(RST), .CE(1'b1), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(rdata), .POWER_SAVE_ENABLE_PIN(pse),
        .HARD_SLEEP_PIN_N(hsl_n), .MAIN_OSC_RUNNING(orun),
        .IRQ_PENDING(irq), .WDOG_TIMEOUT(wto), .CPU_CLK_EN(cpu),
        .PERIPH_CLK_EN(per), .WDOG_CLK_EN(wdc), .SLOW_ACTIVE(slow),
        .OSC_EN(osc), .RC_CLK_SEL(rc), .INT_RESET(irst),
        .PINS_FLOAT(flt), .PORT_HOLD(hold), .STROBE_HOLD_HIGH(strb),
        .WDOG_RUN(wrun), .WDOG_LOAD(wload), .WDOG_RESET_FLAG(wflag),
        .OWD_FLAG(oflag), .IDLE_ACTIVE(idle), .SWPD_ACTIVE(swpd));
    psm_board u_psm_board (
        .clk(CLK), .osc_en(osc), .sleep_req(sleep_req),
        .pse_low(pse_low), .hard_sleep_n(hsl_n), .main_osc_run(orun),
        .pse_pin(pse));
    // ====================================
    // Tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge CLK);
        WR    <= 1'b0;
        @(posedge CLK);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge CLK);
        RD   <= 1'b0;
        @(negedge CLK);
        chk(rdata, exp);
        @(posedge CLK);
        #1;
    endtask : rd
    task automatic rst_pulse(input int unsigned len);
        RST <= 1'b1;
        repeat (len) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        #1;
    endtask : rst_pulse
    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish
    // ====================================
    // Tests
    initial begin
        rst_pulse(3);
        chk(wrun, 8'h01);
        rd(8'h87, 8'h00);
        rd(8'h8e, 8'h38);
        rd(8'h10, 8'h00);
        wr(8'h87, 8'h01);
        wr(8'h87, 8'h20);
        chk(idle, 8'h00);
        wr(8'h87, 8'h10);
        repeat (MC + 2) @(posedge CLK);
        #1;
        chk(slow, 8'h00);
        wr(8'h87, 8'h02);
        wr(8'h87, 8'h40);
        chk(swpd, 8'h00);
        pse_low <= 1'b1;
        repeat (4) @(posedge CLK);
        chk(wrun, 8'h01);
        done("blocked");
        wr(8'h87, 8'h10);
        repeat (MC + 2) @(posedge CLK);
        #1;
        chk(slow, 8'h01);
        rd(8'h87, 8'h10);
        n = 0;
        repeat (16) begin
            @(posedge CLK);
            #1;
            n += (cpu === 1'b1);
        end
        chk(n[7:0], 8'h02);
        wr(8'h87, 8'h00);
        repeat (MC + 2) @(posedge CLK);
        #1;
        chk(slow, 8'h00);
        done("slow");
        wr(8'h87, 8'h01);
        wr(8'h8f, 8'h00);
        wr(8'h87, 8'h20);
        chk(idle, 8'h00);
        wr(8'h87, 8'h01);
        wr(8'h87, 8'h20);
        chk({wdc, cpu, per, hold, idle}, 8'h07);
        irq <= 1'b1;
        @(posedge CLK);
        irq <= 1'b0;
        @(posedge CLK);
        #1;
        chk({wdc, cpu, idle}, 8'h06);
        wr(8'h87, 8'h01);
        wr(8'h87, 8'h20);
        rst_pulse(2 * MC);
        chk({idle, wrun}, 8'h00);
        wr(8'h8f, 8'h01);
        chk(wrun, 8'h01);
        done("idle");
        wr(8'h87, 8'h02);
        wr(8'h87, 8'h40);
        chk({swpd, osc}, 8'h02);
        irq <= 1'b1;
        repeat (2) @(posedge CLK);
        irq <= 1'b0;
        chk(swpd, 8'h01);
        rst_pulse(3);
        chk(swpd, 8'h00);
        done("swpd");
        pse_low <= 1'b0;
        rst_pulse(3);
        wto <= 1'b1;
        @(posedge CLK);
        wto <= 1'b0;
        repeat (2) @(posedge CLK);
        chk(wflag, 8'h01);
        sleep_req <= 1'b1;
        for (i = 0; i < 100 && flt !== 1'b1; i++) begin
            @(posedge CLK);
            #1;
        end
        chk({flt, osc, wrun, wflag}, 8'h08);
        repeat (8) @(posedge CLK);
        chk(flt, 8'h01);
        sleep_req <= 1'b0;
        for (i = 0; i < 100 && flt !== 1'b0; i++) begin
            @(posedge CLK);
            #1;
        end
        chk({rc, irst, osc}, 8'h02);
        @(posedge CLK);
        #1;
        chk({rc, irst, osc}, 8'h07);
        for (i = 0; i < 200 && irst !== 1'b0; i++) begin
            @(posedge CLK);
            #1;
        end
        chk({oflag, wrun, wload}, 8'h07);
        sleep_req <= 1'b1;
        for (i = 0; i < 100 && flt !== 1'b1; i++) begin
            @(posedge CLK);
            #1;
        end
        rst_pulse(3);
        chk({flt, osc}, 8'h01);
        sleep_req <= 1'b0;
        done("hard_sleep_pin");
        tally_and_finish();
    end
    initial begin
        repeat (5000) @(posedge CLK);
        num_errors++;
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
